// file: logic/nvm_spi_consts.vh
// Constants for the serial nonvolatile memory command engine
`ifndef NVM_SPI_CONSTS_VH
`define NVM_SPI_CONSTS_VH
`define OP_SET_LATCH    8'h06
`define OP_CLEAR_LATCH  8'h04
`define OP_STATUS_READ  8'h05
`define OP_STATUS_WRITE 8'h01
`define OP_MEM_READ     8'h03
`define OP_MEM_WRITE    8'h02
`define OP_IDENT_READ   8'h9f
`define OP_FAST_READ    8'h0b
`define OP_SLEEP        8'hb9
`define ST_GUARD_EN_BIT 7
`define ST_BLOCK1_BIT   3
`define ST_BLOCK0_BIT   2
`define ST_LATCH_BIT    1
`define ST_NV_MASK      8'hfc
`define ST_RESET        8'h00
`define WAKE_TIME_US    400
`define MCLK_MHZ        250
`define WAKE_CYCLES     (`WAKE_TIME_US * `MCLK_MHZ)
`define IDENT_WORD      32'h5a_7f_12_34
`endif

// file: logic/nvm_spi_fifo.v
// Parameterised FIFO with valid and ready on both sides
`timescale 1ns/10ps
module nvm_spi_fifo #(
  parameter WIDTH = 24,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input  wire             mclk,
  input  wire             rst_n,
  input  wire [WIDTH-1:0] in_data,
  input  wire             in_valid,
  output wire             in_ready,
  output reg  [WIDTH-1:0] out_data,
  output wire             out_valid,
  input  wire             out_ready
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wr_q;
  reg [AW:0]      rd_q;
  wire            full  = (wr_q[AW-1:0] == rd_q[AW-1:0]) && (wr_q[AW] != rd_q[AW]);
  wire            empty = (wr_q == rd_q);
  assign in_ready  = ~full;
  assign out_valid = ~empty;
  // Pointers carry one extra wrap bit so full and empty differ
  always @(posedge mclk) begin
    if (!rst_n) begin
      wr_q <= {(AW+1){1'b0}};
      rd_q <= {(AW+1){1'b0}};
    end else begin
      if (in_valid && !full) begin
        mem[wr_q[AW-1:0]] <= in_data;
        wr_q <= wr_q + 1'b1;
      end
      if (out_ready && !empty)
        rd_q <= rd_q + 1'b1;
    end
  end
  always @* begin
    out_data = mem[rd_q[AW-1:0]];
  end
endmodule

// file: logic/nvm_spi_slave.v
// Serial slave command engine of a 64K x 8 nonvolatile memory
`timescale 1ns/10ps
`include "nvm_spi_consts.vh"
// Functional notes
// - First eight bits after select falls form the op-code, decoded.
// - Select rising before eight op-code bits executes nothing.
// - Set-latch op-code sets the write enable latch.
// - Clear-latch op-code clears latch; clear latch blocks all writes.
// - Latch clears at reset, clear command, end of write, and wake.
// - Status read shifts status out, repeating while clocks continue.
// - Bit7 guard enable, bits3:2 block guard, bits6:4 spare storage.
// - Status write stores eight bits, ignoring bit1 and bit0.
// - Memory read takes 16-bit address then shifts out byte.
// - Further read bytes use incremented address, wrapping to zero.
// - Memory write takes address, writes each byte at eighth bit.
// - Further write bytes go to successive addresses; select ends write.
// - Fast read adds eight dummy bits after address, else like read.
// - Identity read shifts out 32-bit identifier, maker code first.
// - After 32nd identifier bit output holds that last bit.
// - Sleep op-code enters sleep at select rise, cancelled by clocks.
// - Asleep, clock and data input ignored, output released.
// - Select falling wakes device within 400 microseconds.
// - Input sampled on rising clock, output changed on falling.
// - Select high deselects, inputs ignored, output released.
// - Status write needs latch and guard clear or pin high.
module nvm_spi_slave #(
  parameter WAKE_CYCLES = `WAKE_CYCLES,
  parameter FIFO_DEPTH  = 32
) (
  input  wire mclk,
  input  wire rst_n,
  input  wire cs_n_pin,
  input  wire sck_pin,
  input  wire si_pin,
  input  wire wp_pin,
  output reg  so_out,
  output reg  so_oe,
  output wire asleep,
  output wire write_stall
);
  // Command phases
  localparam PH_OP    = 3'd0;
  localparam PH_ADDR  = 3'd1;
  localparam PH_DUMMY = 3'd2;
  localparam PH_RDATA = 3'd3;
  localparam PH_WDATA = 3'd4;
  localparam PH_SDATA = 3'd5;
  localparam PH_OUT   = 3'd6;
  localparam PH_IDLE  = 3'd7;

  // Protection check used for every memory write
  function blocked;
    input [15:0] a;
    input [1:0]  bp;
    begin
      case (bp)
        2'b00:   blocked = 1'b0;
        2'b01:   blocked = (a[15:14] == 2'b11);
        2'b10:   blocked = a[15];
        default: blocked = 1'b1;
      endcase
    end
  endfunction

  reg [7:0]  mem [0:65535];
  reg [2:0]  cs_s_q, sck_s_q, si_s_q, wp_s_q;
  reg [2:0]  ph_q;
  reg [7:0]  op_q;
  reg [7:0]  sh_q;
  reg [4:0]  cnt_q;
  reg [15:0] addr_q;
  reg [31:0] out_q;
  reg [5:0]  out_cnt_q;
  reg [7:0]  st_q;
  reg        latch_q;
  reg        wrote_q;
  reg        sleep_req_q;
  reg        sleep_q;
  reg        waking_q;
  reg [31:0] wake_q;
  wire       cs_n   = cs_s_q[1];
  wire       cs_fall = cs_s_q[2] & ~cs_s_q[1];
  wire       cs_rise = ~cs_s_q[2] & cs_s_q[1];
  wire       sck_rise = ~sck_s_q[2] & sck_s_q[1];
  wire       sck_fall = sck_s_q[2] & ~sck_s_q[1];
  wire       si     = si_s_q[1];
  wire       wp     = wp_s_q[1];
  wire       active = ~cs_n & ~sleep_q & ~waking_q;
  wire [7:0] sh_next = {sh_q[6:0], si};
  wire [7:0] st_view = {st_q[7:2], latch_q, 1'b0};

  // Write path through the buffer into the array
  reg        wr_push;
  reg [23:0] wr_word;
  wire       wr_ready;
  wire [23:0] fifo_data;
  wire       fifo_valid;
  assign write_stall = ~wr_ready;
  assign asleep      = sleep_q | waking_q;
  nvm_spi_fifo #(.WIDTH(24), .DEPTH(FIFO_DEPTH), .AW(5)) u_fifo (
    .mclk      (mclk),
    .rst_n     (rst_n),
    .in_data   (wr_word),
    .in_valid  (wr_push),
    .in_ready  (wr_ready),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (1'b1)
  );
  // Array write drains one word each cycle
  always @(posedge mclk) begin
    if (fifo_valid)
      mem[fifo_data[23:8]] <= fifo_data[7:0];
  end

  // Two-flop sync of every pin; third stage only for edge finding
  always @(posedge mclk) begin
    if (!rst_n) begin
      cs_s_q  <= 3'h7;
      sck_s_q <= 3'h0;
      si_s_q  <= 3'h0;
      wp_s_q  <= 3'h0;
    end else begin
      cs_s_q  <= {cs_s_q[1:0], cs_n_pin};
      sck_s_q <= {sck_s_q[1:0], sck_pin};
      si_s_q  <= {si_s_q[1:0], si_pin};
      wp_s_q  <= {wp_s_q[1:0], wp_pin};
    end
  end

  // Sleep entry and wake recovery
  always @(posedge mclk) begin
    if (!rst_n) begin
      sleep_q  <= 1'b0;
      waking_q <= 1'b0;
      wake_q   <= 32'h0;
    end else if (sleep_q) begin
      if (cs_fall) begin
        sleep_q  <= 1'b0;
        waking_q <= 1'b1;
        wake_q   <= 32'h0;
      end
    end else if (waking_q) begin
      wake_q <= wake_q + 32'h1;
      if (wake_q >= WAKE_CYCLES - 1)
        waking_q <= 1'b0;
    end else if (cs_rise && sleep_req_q) begin
      sleep_q <= 1'b1;
    end
  end

  // Command engine on decoded serial clock edges
  always @(posedge mclk) begin
    wr_push <= 1'b0;
    wr_word <= 24'h0;
    if (!rst_n) begin
      ph_q        <= PH_OP;
      op_q        <= 8'h0;
      sh_q        <= 8'h0;
      cnt_q       <= 5'h0;
      addr_q      <= 16'h0;
      out_q       <= 32'h0;
      out_cnt_q   <= 6'h0;
      st_q        <= `ST_RESET;
      latch_q     <= 1'b0;
      wrote_q     <= 1'b0;
      sleep_req_q <= 1'b0;
      so_out      <= 1'b0;
      so_oe       <= 1'b0;
    end else if (!active) begin
      // Deselected or asleep: frame state drops, output released
      ph_q        <= PH_OP;
      cnt_q       <= 5'h0;
      so_oe       <= 1'b0;
      sleep_req_q <= 1'b0;
      if (cs_rise && wrote_q)
        latch_q <= 1'b0;
      if (sleep_q && cs_fall)
        latch_q <= 1'b0;
      wrote_q <= 1'b0;
    end else begin
      so_oe <= 1'b1;
      if (sck_rise) begin
        // Input sampled on rising edge, MSB first
        sh_q        <= sh_next;
        cnt_q       <= cnt_q + 5'h1;
        sleep_req_q <= 1'b0;
        case (ph_q)
          PH_OP: begin
            if (cnt_q == 5'd7) begin
              op_q  <= sh_next;
              cnt_q <= 5'h0;
              case (sh_next)
                `OP_SET_LATCH:   begin latch_q <= 1'b1; ph_q <= PH_IDLE; end
                `OP_CLEAR_LATCH: begin latch_q <= 1'b0; ph_q <= PH_IDLE; end
                `OP_STATUS_READ: begin
                  out_q     <= {st_view, 24'h0};
                  out_cnt_q <= 6'd8;
                  ph_q      <= PH_OUT;
                end
                `OP_STATUS_WRITE: begin ph_q <= PH_SDATA; wrote_q <= 1'b1; end
                `OP_MEM_READ, `OP_MEM_WRITE, `OP_FAST_READ: ph_q <= PH_ADDR;
                `OP_IDENT_READ: begin
                  out_q     <= `IDENT_WORD;
                  out_cnt_q <= 6'd32;
                  ph_q      <= PH_OUT;
                end
                `OP_SLEEP: begin sleep_req_q <= 1'b1; ph_q <= PH_IDLE; end
                default: ph_q <= PH_IDLE;
              endcase
            end
          end
          PH_ADDR: begin
            addr_q <= {addr_q[14:0], si};
            if (cnt_q == 5'd15) begin
              cnt_q <= 5'h0;
              if (op_q == `OP_MEM_WRITE) begin
                ph_q    <= PH_WDATA;
                wrote_q <= 1'b1;
              end else if (op_q == `OP_FAST_READ)
                ph_q <= PH_DUMMY;
              else
                ph_q <= PH_RDATA;
            end
          end
          PH_DUMMY: begin
            if (cnt_q == 5'd7) begin
              cnt_q <= 5'h0;
              ph_q  <= PH_RDATA;
            end
          end
          PH_WDATA: begin
            if (cnt_q == 5'd7) begin
              cnt_q  <= 5'h0;
              addr_q <= addr_q + 16'h1;
              // Latch and block guard gate each byte
              if (latch_q && !blocked(addr_q, st_q[3:2])) begin
                wr_push <= 1'b1;
                wr_word <= {addr_q, sh_next};
              end
            end
          end
          PH_SDATA: begin
            if (cnt_q == 5'd7) begin
              cnt_q <= 5'h0;
              ph_q  <= PH_IDLE;
              if (latch_q && (!st_q[`ST_GUARD_EN_BIT] || wp))
                st_q <= sh_next & `ST_NV_MASK;
            end
          end
          PH_RDATA: begin
            // Wrap on the eighth rise so the next fall loads a fresh byte
            if (cnt_q == 5'd7)
              cnt_q <= 5'h0;
          end
          default: ;
        endcase
      end
      if (sck_fall) begin
        // Output changes on falling edge
        case (ph_q)
          PH_RDATA: begin
            if (cnt_q == 5'd0) begin
              so_out <= mem[addr_q][7];
              out_q  <= {mem[addr_q][6:0], 25'h0};
              addr_q <= addr_q + 16'h1;
            end else begin
              so_out <= out_q[31];
              out_q  <= {out_q[30:0], 1'b0};
            end
          end
          PH_OUT: begin
            if (out_cnt_q != 6'd0) begin
              so_out    <= out_q[31];
              out_q     <= {out_q[30:0], 1'b0};
              out_cnt_q <= out_cnt_q - 6'd1;
            end else if (op_q == `OP_STATUS_READ) begin
              so_out    <= st_view[7];
              out_q     <= {st_view[6:0], 25'h0};
              out_cnt_q <= 6'd7;
            end
            // Identity output simply holds its last bit
          end
          default: ;
        endcase
      end
    end
  end
endmodule

// file: tb/nvm_spi_checker.sv
// Port checker for the serial memory command engine
`timescale 1ns/10ps
module nvm_spi_checker #(
  parameter WAKE_CYCLES = 50
) (
  input wire mclk,
  input wire rst_n,
  input wire cs_n_pin,
  input wire sck_pin,
  input wire si_pin,
  input wire wp_pin,
  input wire so_out,
  input wire so_oe,
  input wire asleep,
  input wire write_stall
);
  // Margin covers the two-flop pin synchronisers
  localparam int WK = WAKE_CYCLES + 20;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  sequence deselect_held;
    cs_n_pin [*6];
  endsequence
  sequence shift_high;
    (!cs_n_pin && sck_pin) [*6];
  endsequence
  chk_deselect_quiet: assert property (deselect_held |-> !so_oe)
    else $error("output enabled while deselected");
  chk_release_bound: assert property ($rose(cs_n_pin) |-> ##[1:6] !so_oe)
    else $error("output not released after deselect");
  chk_oe_selected: assert property ($rose(so_oe) |-> !cs_n_pin && !asleep)
    else $error("output enabled without selection");
  chk_shift_stable: assert property (shift_high |-> $stable(so_out))
    else $error("output changed while serial clock high");
  chk_sleep_silent: assert property (asleep |-> !so_oe)
    else $error("output enabled while asleep");
  chk_sleep_entry: assert property ($rose(asleep) |-> cs_n_pin)
    else $error("sleep entered while selected");
  chk_wake_bound: assert property ($fell(cs_n_pin) && asleep |-> ##[1:WK] !asleep)
    else $error("wake recovery too long");
  chk_reset_quiet: assert property ($rose(rst_n) |-> !so_oe && !asleep)
    else $error("outputs active after reset");
endmodule
bind nvm_spi_slave nvm_spi_checker #(.WAKE_CYCLES(WAKE_CYCLES)) chk_u (
  .mclk        (mclk),
  .rst_n       (rst_n),
  .cs_n_pin    (cs_n_pin),
  .sck_pin     (sck_pin),
  .si_pin      (si_pin),
  .wp_pin      (wp_pin),
  .so_out      (so_out),
  .so_oe       (so_oe),
  .asleep      (asleep),
  .write_stall (write_stall)
);

// file: tb/spi_host.sv
// Serial host model, mode 0, clock still outside frames
`timescale 1ns/10ps
module spi_host (
  output logic cs_n,
  output logic sck,
  output logic si,
  input  wire  so
);
  initial begin
    cs_n = 1'b1;
    sck  = 1'b0;
    si   = 1'b0;
  end
  // Data set while clock low, sampled at rise, msb first
  task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
    rx = 8'h00;
    for (int i = 7; i > 7 - n; i--) begin
      si = tx[i];
      #62.5 sck = 1'b1;
      rx[i] = so;
      #62.5 sck = 1'b0;
    end
  endtask
  // Select edge with idle gaps; released data line flips
  task automatic sel(input logic lo);
    #250 cs_n = !lo;
    if (!lo)
      si = ~si;
    #250;
  endtask
endmodule

// file: tb/tb_top.sv
// Self-checking bench for the serial memory command engine
`timescale 1ns/10ps
`include "nvm_spi_consts.vh"
module tb_top;
  logic        mclk, rst_n, wp_pin;
  wire         cs_n, sck, si, so_out, so_oe, asleep, write_stall;
  wire         so_w = so_oe ? so_out : 1'bz;
  logic [7:0]  r, st, d;
  logic [15:0] a;
  logic [31:0] idw = `IDENT_WORD;
  logic [7:0]  mem [bit [15:0]];
  int          n_mismatch, checks_done, seed;
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  nvm_spi_slave #(.WAKE_CYCLES(50)) dut_u (
    .mclk        (mclk),
    .rst_n       (rst_n),
    .cs_n_pin    (cs_n),
    .sck_pin     (sck),
    .si_pin      (si),
    .wp_pin      (wp_pin),
    .so_out      (so_out),
    .so_oe       (so_oe),
    .asleep      (asleep),
    .write_stall (write_stall)
  );
  spi_host host_u (.cs_n(cs_n), .sck(sck), .si(si), .so(so_w));
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic b(input logic [7:0] x);
    host_u.xfer(x, 8, r);
  endtask
  task automatic op(input logic [7:0] c);
    host_u.sel(1'b1);
    b(c);
  endtask
  task automatic fin;
    host_u.sel(1'b0);
  endtask
  task automatic f1(input logic [7:0] c);
    op(c);
    fin;
  endtask
  // Status read twice in one frame, random input ignored
  task automatic rs(input logic [7:0] e);
    op(8'h05);
    b(8'($random(seed)));
    chk("status", e, r);
    b(8'($random(seed)));
    chk("status again", e, r);
    fin;
  endtask
  task automatic ws(input logic [7:0] v);
    f1(8'h06);
    op(8'h01);
    b(v);
    fin;
  endtask
  task automatic mw(input logic [15:0] ad, input int n);
    f1(8'h06);
    op(8'h02);
    b(ad[15:8]);
    b(ad[7:0]);
    for (int i = 0; i < n; i++) begin
      d = 8'($random(seed));
      b(d);
      mem[16'(ad + i)] = d;
    end
    fin;
  endtask
  function automatic logic [7:0] exp_byte(bit [15:0] x);
    return mem.exists(x) ? mem[x] : 8'h00;
  endfunction
  task automatic mr(input logic [7:0] c, input logic [15:0] ad, input int n);
    op(c);
    b(ad[15:8]);
    b(ad[7:0]);
    if (c == 8'h0b)
      b(8'h5a);
    for (int i = 0; i < n; i++) begin
      b(8'($random(seed)));
      chk("read", exp_byte(16'(ad + i)), r);
    end
    fin;
  endtask
  task automatic end_of_test;
    $display("mismatches %0d checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Whole sequence takes well under half a millisecond
  initial begin
    #380_000;
    n_mismatch++;
    end_of_test;
  end
  initial begin
    seed = 32'hf4f6;
    rst_n = 1'b0;
    wp_pin = 1'b0;
    repeat (2) @(posedge mclk);
    #1 rst_n = 1'b1;
    repeat (4) @(posedge mclk);
    rs(8'h00);
    f1(8'h06);
    rs(8'h02);
    f1(8'h04);
    rs(8'h00);
    // Seven op-code bits only, then a write with latch clear
    host_u.sel(1'b1);
    host_u.xfer(8'h06, 7, r);
    fin;
    op(8'h01);
    b(8'hfc);
    fin;
    rs(8'h00);
    st = 8'($random(seed)) & 8'h70;
    ws(st | 8'h03);
    rs(st);
    @(posedge mclk) #1 wp_pin = 1'b1;
    ws(8'h80);
    @(posedge mclk) #1 wp_pin = 1'b0;
    ws(8'h0c);
    rs(8'h80);
    @(posedge mclk) #1 wp_pin = 1'b1;
    ws(8'h00);
    mw(16'hfffe, 3);
    mr(8'h03, 16'hfffe, 3);
    mr(8'h0b, 16'hffff, 2);
    op(8'h02);
    b(8'hff);
    b(8'hfe);
    b(~mem[16'hfffe]);
    fin;
    mr(8'h03, 16'hfffe, 1);
    for (int k = 0; k < 4; k++) begin
      a = 16'($random(seed));
      mw(a, 2);
      mr(8'h03, a, 2);
    end
    chk("write_stall", 1'b0, write_stall);
    op(8'h9f);
    for (int k = 0; k < 6; k++) begin
      b(8'($random(seed)));
      chk("ident", k < 4 ? idw[31-8*k -: 8] : {8{idw[0]}}, r);
    end
    fin;
    f1(8'h06);
    op(8'hb9);
    host_u.xfer(8'h00, 1, r);
    fin;
    chk("asleep", 1'b0, asleep);
    f1(8'hb9);
    chk("asleep", 1'b1, asleep);
    chk("so_oe", 1'b0, so_oe);
    host_u.sel(1'b1);
    repeat (40) @(posedge mclk);
    chk("asleep", 1'b0, asleep);
    fin;
    rs(8'h00);
    end_of_test;
  end
endmodule
